// >>> design/bms_boot.v
// Purpose: boot-mode sense and factory-restore control with APB access
// Assumes: presetn is the power-up reset; wifi_reset_n is a pin
// Notes: core reset output is held low until the code is latched
`timescale 1ns/1ps
`default_nettype none
`include "bms_defs.vh"
module bms_boot #(
  parameter RESTORE_CYC = `BMS_RESTORE_MS * `BMS_CLK_KHZ,
  parameter BREAK_CYC = `BMS_BREAK_US * `BMS_CLK_KHZ / 1000
) (
  // Clock and power-up reset
  input wire pclk,
  input wire presetn,
  // APB slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  // Pins
  input wire wifi_reset_n,
  input wire [2:0] boot_sense_pins,
  input wire uart_rx,
  // Sense pins as antenna switch after boot
  output reg [1:0] ant_sw_out,
  output reg [1:0] ant_sw_oe,
  output reg [2:0] sense_pd_en,
  // Boot flow outputs
  output reg wifi_core_reset_n,
  output reg uart_load_mode,
  output reg func_four_wire_debug,
  output reg func_two_wire_debug,
  output reg factory_restore_mode,
  output reg [1:0] restore_kind,
  output reg rom_loader_run,
  output reg flash_access_deny
);
  ////////////////////////////////////////////////////////////////////////
  // States
  localparam [5:0] S_OFF = 6'b000001;
  localparam [5:0] S_SENSE = 6'b000010;
  localparam [5:0] S_BRK = 6'b000100;
  localparam [5:0] S_LOAD = 6'b001000;
  localparam [5:0] S_RESTORE = 6'b010000;
  localparam [5:0] S_RUN = 6'b100000;

  function [2:0] mode_of;
    input [2:0] code;
    begin
      case (code)
        `BMS_CODE_LOAD: mode_of = `BMS_MODE_LOAD;
        `BMS_CODE_FN2: mode_of = `BMS_MODE_FN2;
        `BMS_CODE_RST: mode_of = `BMS_MODE_RESTORE;
        `BMS_CODE_BRK: mode_of = `BMS_MODE_LOAD;
        `BMS_CODE_FN4: mode_of = `BMS_MODE_FN4;
        default: mode_of = `BMS_MODE_FN4;
      endcase
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  wire [2:0] sense_s;
  wire rst_pin_s;
  wire rx_s;
  bms_sync #(.W(5)) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .din({boot_sense_pins, wifi_reset_n, uart_rx}),
    .dout({sense_s, rst_pin_s, rx_s})
  );

  ////////////////////////////////////////////////////////////////////////
  // Restore progress word: {pending, kind, unused}
  reg nv_we;
  reg [3:0] nv_wdata;
  wire [3:0] nv_rdata;
  bms_nv #(.W(4)) u_nv (
    .pclk(pclk),
    .por_n(presetn),
    .we(nv_we),
    .wdata(nv_wdata),
    .rdata(nv_rdata)
  );

  ////////////////////////////////////////////////////////////////////////
  reg [5:0] state;
  reg [2:0] code;
  reg [2:0] mode;
  reg [31:0] cnt;
  reg rst_pin_d;
  reg done;
  reg flash_has_prog;
  reg [1:0] restore_cfg;
  reg [1:0] ant_cfg;
  reg sw_restore_req;
  wire apb_acc = psel & penable;
  wire apb_wr = apb_acc & pwrite;
  // Shutdown while the reset pin is low; re-sense on every rising edge of it
  wire pin_rise = rst_pin_s & ~rst_pin_d;
  wire resume = nv_rdata[3];

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= S_OFF;
      code <= 3'h0;
      mode <= `BMS_MODE_FN4;
      cnt <= 32'h0000_0000;
      rst_pin_d <= 1'b0;
      done <= 1'b0;
      nv_we <= 1'b0;
      nv_wdata <= 4'h0;
      sw_restore_req <= 1'b0;
    end else begin
      rst_pin_d <= rst_pin_s;
      nv_we <= 1'b0;
      if (!rst_pin_s) begin
        state <= S_OFF;
      end else begin
        case (state)
          S_OFF: begin
            if (pin_rise) begin
              state <= S_SENSE;
              cnt <= 32'h0000_0000;
            end
          end
          S_SENSE: begin
            // Pins settle before the latch; pull-downs are on here
            cnt <= cnt + 32'h0000_0001;
            if (cnt == `BMS_SETTLE_CYC) begin
              code <= sense_s;
              mode <= mode_of(sense_s);
              cnt <= 32'h0000_0000;
              if (resume || sense_s == `BMS_CODE_RST) begin
                state <= S_RESTORE;
                mode <= `BMS_MODE_RESTORE;
                nv_we <= 1'b1;
                done <= 1'b0;
                nv_wdata <= {1'b1, resume ? nv_rdata[2:1] : restore_cfg,
                             1'b0};
              end else if (sense_s == `BMS_CODE_LOAD) begin
                state <= S_LOAD;
              end else if (sense_s == `BMS_CODE_BRK) begin
                state <= S_BRK;
              end else begin
                state <= S_RUN;
              end
            end
          end
          S_BRK: begin
            // A break is a low receive line held for the whole window
            cnt <= cnt + 32'h0000_0001;
            if (rx_s) begin
              state <= S_RUN;
              mode <= `BMS_MODE_FN4;
            end else if (cnt >= BREAK_CYC - 1) begin
              state <= S_LOAD;
            end
          end
          S_LOAD: begin
            // No timeout: leaves only through a new reset, whatever the code
            state <= S_LOAD;
          end
          S_RESTORE: begin
            cnt <= cnt + 32'h0000_0001;
            if (cnt >= RESTORE_CYC - 1) begin
              state <= S_RUN;
              mode <= `BMS_MODE_FN4;
              done <= 1'b1;
              nv_we <= 1'b1;
              nv_wdata <= 4'h0;
            end
          end
          S_RUN: begin
            if (sw_restore_req) begin
              sw_restore_req <= 1'b0;
              state <= S_RESTORE;
              mode <= `BMS_MODE_RESTORE;
              cnt <= 32'h0000_0000;
              done <= 1'b0;
              nv_we <= 1'b1;
              nv_wdata <= {1'b1, restore_cfg, 1'b0};
            end
          end
          default: state <= S_OFF;
        endcase
      end
      // Placed last so a new request beats the clear of a taken one
      if (apb_wr && paddr == `BMS_OFF_CTRL && pwdata[2]) begin
        sw_restore_req <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Registers written by software
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      restore_cfg <= `BMS_RS_IMAGE;
      ant_cfg <= 2'h0;
      flash_has_prog <= 1'b0;
    end else if (apb_wr) begin
      case (paddr)
        `BMS_OFF_CTRL: ant_cfg <= pwdata[1:0];
        `BMS_OFF_RESTORE: restore_cfg <= pwdata[1:0];
        `BMS_OFF_FLASH: flash_has_prog <= pwdata[0];
        default: ant_cfg <= ant_cfg;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // APB answer: one access cycle, no wait states
  wire known = (paddr == `BMS_OFF_STATUS) || (paddr == `BMS_OFF_CTRL) ||
               (paddr == `BMS_OFF_RESTORE) || (paddr == `BMS_OFF_FLASH);
  reg [31:0] next_prdata;
  always @* begin
    next_prdata = 32'h0000_0000;
    case (paddr)
      `BMS_OFF_STATUS: begin
        next_prdata[`BMS_ST_CODE_LSB +: 3] = code;
        next_prdata[`BMS_ST_MODE_LSB +: 3] = mode;
        next_prdata[`BMS_ST_BUSY] = (state == S_RESTORE);
        next_prdata[`BMS_ST_DONE] = done;
        next_prdata[`BMS_ST_FOURW] = (mode != `BMS_MODE_FN2);
        next_prdata[`BMS_ST_PEND] = resume;
      end
      `BMS_OFF_CTRL: next_prdata[1:0] = ant_cfg;
      `BMS_OFF_RESTORE: next_prdata[1:0] = restore_cfg;
      `BMS_OFF_FLASH: next_prdata[0] = flash_has_prog;
      default: next_prdata = 32'h0000_0000;
    endcase
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel & ~penable;
      pslverr <= psel & ~penable & ~known;
      if (psel && !penable && !pwrite) begin
        prdata <= next_prdata;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Pin and flow outputs
  wire booted = (state == S_RUN);
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wifi_core_reset_n <= 1'b0;
      uart_load_mode <= 1'b0;
      func_four_wire_debug <= 1'b0;
      func_two_wire_debug <= 1'b0;
      factory_restore_mode <= 1'b0;
      restore_kind <= `BMS_RS_NONE;
      rom_loader_run <= 1'b0;
      flash_access_deny <= 1'b1;
      ant_sw_out <= 2'h0;
      ant_sw_oe <= 2'h0;
      sense_pd_en <= 3'h7;
    end else begin
      // Core stays in reset until the code is latched
      wifi_core_reset_n <= (state != S_OFF) && (state != S_SENSE);
      uart_load_mode <= (state == S_LOAD);
      func_two_wire_debug <= booted && mode == `BMS_MODE_FN2;
      func_four_wire_debug <= (state == S_LOAD) ||
                              (booted && mode != `BMS_MODE_FN2);
      factory_restore_mode <= (state == S_RESTORE);
      // Progress word lands a cycle late; show the value being written
      restore_kind <= (state != S_RESTORE) ? `BMS_RS_NONE :
                      nv_we ? nv_wdata[2:1] : nv_rdata[2:1];
      rom_loader_run <= (state == S_LOAD) ||
                        (booted && !flash_has_prog);
      flash_access_deny <= 1'b1;
      // All pull-downs on while sensing; only sense_pd_en[2] stays on after
      sense_pd_en <= (state == S_OFF || state == S_SENSE) ? 3'h7 : 3'h4;
      ant_sw_oe <= booted ? 2'h3 : 2'h0;
      ant_sw_out <= booted ? ant_cfg : 2'h0;
    end
  end
endmodule // bms_boot
`default_nettype wire

// >>> shared/bms_defs.vh
// Purpose: constants for the boot-mode sense and restore block
// Assumes: 32-bit APB register words, byte addresses
// Notes: all offsets are byte addresses
`ifndef BMS_DEFS_VH
`define BMS_DEFS_VH
// Register offsets
`define BMS_OFF_STATUS 12'h000
`define BMS_OFF_CTRL 12'h004
`define BMS_OFF_RESTORE 12'h008
`define BMS_OFF_FLASH 12'h00C
// Sense codes
`define BMS_CODE_FN4 3'h0
`define BMS_CODE_FN2 3'h1
`define BMS_CODE_BRK 3'h2
`define BMS_CODE_RST 3'h3
`define BMS_CODE_LOAD 3'h4
// Mode numbers reported in status
`define BMS_MODE_FN4 3'h0
`define BMS_MODE_FN2 3'h1
`define BMS_MODE_LOAD 3'h2
`define BMS_MODE_RESTORE 3'h3
// Restore settings
`define BMS_RS_NONE 2'h0
`define BMS_RS_PARAMS 2'h1
`define BMS_RS_IMAGE 2'h2
// Status field positions
`define BMS_ST_CODE_LSB 0
`define BMS_ST_MODE_LSB 4
`define BMS_ST_BUSY 8
`define BMS_ST_DONE 9
`define BMS_ST_FOURW 10
`define BMS_ST_PEND 11
// Timing
`define BMS_RESTORE_MS 8000
`define BMS_CLK_KHZ 25000
`define BMS_BREAK_US 100
`define BMS_SETTLE_CYC 16
`endif

// >>> design/bms_sync.v
// Purpose: two-flop synchroniser for asynchronous pin levels
// Assumes: destination clock pclk
// Notes: first stage feeds only the second stage
`timescale 1ns/1ps
`default_nettype none
module bms_sync #(
  parameter W = 1
) (
  // Clock and reset
  input wire pclk,
  input wire presetn,
  // Data
  input wire [W-1:0] din,
  output reg [W-1:0] dout
);
  reg [W-1:0] meta;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta <= {W{1'b0}};
      dout <= {W{1'b0}};
    end else begin
      meta <= din;
      dout <= meta;
    end
  end
endmodule // bms_sync
`default_nettype wire

// >>> design/bms_nv.v
// Purpose: retained restore-progress word, survives wifi_reset_n but not presetn
// Assumes: models the persistent flash progress marker
// Notes: power-up or a write of zero clears it; read data registered
`timescale 1ns/1ps
`default_nettype none
module bms_nv #(
  parameter W = 4
) (
  // Clock and power-on
  input wire pclk,
  input wire por_n,
  // Access
  input wire we,
  input wire [W-1:0] wdata,
  output reg [W-1:0] rdata
);
  reg [W-1:0] mem;
  always @(posedge pclk or negedge por_n) begin
    if (!por_n) begin
      mem <= {W{1'b0}};
      rdata <= {W{1'b0}};
    end else begin
      if (we) begin
        mem <= wdata;
      end
      rdata <= we ? wdata : mem;
    end
  end
endmodule // bms_nv
`default_nettype wire

// >>> test/bms_props.sv
// Purpose: port checks for the boot-mode sense block
// Assumes: bound to bms_boot, single pclk domain
// Notes: presetn disables every check
`timescale 1ns/1ps
`default_nettype none
module bms_props (
  // Clock and reset
  input wire pclk,
  input wire presetn,
  // Bus and pin
  input wire psel,
  input wire penable,
  input wire pready,
  input wire pslverr,
  input wire wifi_reset_n,
  // Boot outputs
  input wire [1:0] ant_sw_oe,
  input wire [2:0] sense_pd_en,
  input wire wifi_core_reset_n,
  input wire uart_load_mode,
  input wire func_four_wire_debug,
  input wire func_two_wire_debug,
  input wire factory_restore_mode,
  input wire [1:0] restore_kind,
  input wire flash_access_deny
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  ////////////////////////////////////////
  chk_pull_down_on: assert property (!wifi_core_reset_n |-> sense_pd_en == 3'h7)
    else $error("pull-downs not all on while held");
  chk_antenna_idle: assert property (!wifi_core_reset_n |-> ant_sw_oe == 2'h0)
    else $error("antenna drive before boot");
  chk_deny_flash: assert property (flash_access_deny)
    else $error("factory sector open");
  chk_ready_pulse: assert property (psel && !penable |=> pready ##1 !pready)
    else $error("ready not one access cycle");
  chk_err_ready: assert property (pslverr |-> pready)
    else $error("error without ready");
  chk_kind_idle: assert property (!factory_restore_mode |-> restore_kind == 2'h0)
    else $error("restore kind outside restore");
  chk_pin_off: assert property ($fell(wifi_reset_n) |-> ##[1:5] !wifi_core_reset_n)
    else $error("shutdown not taken");
  chk_boot_gate: assert property ($rose(wifi_core_reset_n) |-> wifi_reset_n && $past(wifi_reset_n, 16))
    else $error("core released before latch");
  chk_debug_excl: assert property (func_two_wire_debug |-> !func_four_wire_debug && !uart_load_mode)
    else $error("debug modes overlap");
  chk_mode_hold: assert property (wifi_core_reset_n && $past(wifi_core_reset_n) |-> $stable(func_two_wire_debug))
    else $error("mode changed while running");
endmodule // bms_props
`default_nettype wire

// >>> test/bms_strap_model.sv
// Purpose: board straps and host reset pin
// Assumes: unstrapped sense lines fall to the pull-downs
// Notes: uart_rx idles high unless a break is held
`timescale 1ns/1ps
`default_nettype none
module bms_strap_model (
  // Host controls
  input wire logic drive,
  input wire logic [2:0] strap,
  input wire logic pin_hi,
  input wire logic brk,
  // Pins toward the block
  output wire logic wifi_reset_n,
  output wire logic [2:0] boot_sense_pins,
  output wire logic uart_rx
);
  ////////////////////////////////////////
  assign wifi_reset_n = pin_hi;
  assign boot_sense_pins = drive ? strap : 3'h0;
  assign uart_rx = !brk;
endmodule // bms_strap_model
`default_nettype wire

// >>> test/tb.sv
// Purpose: self-checking bench for bms_boot
// Assumes: short restore and break counts
// Notes: every boot goes through a pin shutdown first
`timescale 1ns/1ps
`default_nettype none
`include "bms_defs.vh"
module tb;
  localparam int RCYC = 50;
  localparam int BCYC = 8;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic drive, pin_hi, brk, wifi_reset_n, uart_rx;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [2:0] strap, boot_sense_pins, sense_pd_en;
  logic [1:0] ant_sw_out, ant_sw_oe, restore_kind;
  logic wifi_core_reset_n, uart_load_mode, func_four_wire_debug;
  logic func_two_wire_debug, factory_restore_mode, rom_loader_run;
  logic flash_access_deny;
  int n_errors, n_tests;
  bms_strap_model bms_strap_model_inst (.drive(drive), .strap(strap),
    .pin_hi(pin_hi), .brk(brk), .wifi_reset_n(wifi_reset_n),
    .boot_sense_pins(boot_sense_pins), .uart_rx(uart_rx));
  bms_boot #(.RESTORE_CYC(RCYC), .BREAK_CYC(BCYC)) bms_boot_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .wifi_reset_n(wifi_reset_n),
    .boot_sense_pins(boot_sense_pins), .uart_rx(uart_rx),
    .ant_sw_out(ant_sw_out), .ant_sw_oe(ant_sw_oe),
    .sense_pd_en(sense_pd_en), .wifi_core_reset_n(wifi_core_reset_n),
    .uart_load_mode(uart_load_mode),
    .func_four_wire_debug(func_four_wire_debug),
    .func_two_wire_debug(func_two_wire_debug),
    .factory_restore_mode(factory_restore_mode),
    .restore_kind(restore_kind), .rom_loader_run(rom_loader_run),
    .flash_access_deny(flash_access_deny));
  ////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Shutdown, new straps, then release and let the break check settle
  task automatic boot(input logic [2:0] c, input logic b);
    @(posedge pclk);
    pin_hi <= 1'b0;
    strap <= c;
    brk <= b;
    drive <= 1'b1;
    repeat (8) @(posedge pclk);
    pin_hi <= 1'b1;
    do @(posedge pclk); while (wifi_core_reset_n !== 1'b1);
    repeat (BCYC + 6) @(posedge pclk);
  endtask
  task automatic t_regs;
    apb(1'b0, `BMS_OFF_RESTORE, 32'h0000_0000);
    chk(rd, 32'h0000_0002);
    apb(1'b0, `BMS_OFF_FLASH, 32'h0000_0000);
    chk(rd, 32'h0000_0000);
    chk(32'(flash_access_deny), 32'h0000_0001);
    apb(1'b1, 12'h010, 32'h0000_0003);
    chk(32'(err), 32'h0000_0001);
    apb(1'b0, 12'h010, 32'h0000_0000);
    chk({rd[30:0], err}, 32'h0000_0001);
  endtask
  task automatic t_modes;
    logic [2:0] c;
    logic [2:0] m;
    for (int i = 0; i < 8; i++) begin
      c = i[2:0];
      m = (c == 3'h1) ? `BMS_MODE_FN2 : (c == 3'h4) ? `BMS_MODE_LOAD : 3'h0;
      if (c != `BMS_CODE_RST) begin
        boot(c, 1'b0);
        apb(1'b0, `BMS_OFF_STATUS, 32'h0000_0000);
        chk(32'(rd[2:0]), 32'(c));
        chk(32'(rd[6:4]), 32'(m));
        chk(32'(rd[10]), 32'(c != 3'h1));
        chk(32'(func_two_wire_debug), 32'(c == 3'h1));
        chk(32'(func_four_wire_debug), 32'(c != 3'h1));
        chk(32'(uart_load_mode), 32'(c == 3'h4));
      end
    end
  endtask
  task automatic t_break_hold;
    boot(`BMS_CODE_BRK, 1'b1);
    chk(32'(uart_load_mode), 32'h0000_0001);
    boot(`BMS_CODE_FN2, 1'b0);
    chk(32'(uart_load_mode), 32'h0000_0000);
    chk(32'(rom_loader_run), 32'h0000_0001);
    strap <= `BMS_CODE_LOAD;
    apb(1'b1, `BMS_OFF_CTRL, 32'h0000_0002);
    repeat (2) @(posedge pclk);
    chk({ant_sw_out, ant_sw_oe, 1'b0, sense_pd_en}, 32'h0000_00B4);
    apb(1'b0, `BMS_OFF_STATUS, 32'h0000_0000);
    chk(32'(rd[2:0]), 32'h0000_0001);
    apb(1'b1, `BMS_OFF_FLASH, 32'h0000_0001);
    boot(`BMS_CODE_FN4, 1'b0);
    chk(32'(rom_loader_run), 32'h0000_0000);
  endtask
  task automatic t_restore(input logic [1:0] k, input logic cut);
    apb(1'b1, `BMS_OFF_RESTORE, 32'(k));
    boot(`BMS_CODE_RST, 1'b0);
    chk({factory_restore_mode, restore_kind}, 32'({1'b1, k}));
    if (cut) boot(`BMS_CODE_FN4, 1'b0);
    chk(32'(factory_restore_mode), 32'h0000_0001);
    apb(1'b0, `BMS_OFF_STATUS, 32'h0000_0000);
    chk(32'({rd[11], rd[8]}), 32'h0000_0003);
    do @(posedge pclk); while (factory_restore_mode !== 1'b0);
    apb(1'b0, `BMS_OFF_STATUS, 32'h0000_0000);
    chk(32'({rd[9], rd[6:4]}), 32'h0000_0008);
  endtask
  // Software restore from a running four-wire boot, last setting kept
  task automatic t_sw_restore;
    apb(1'b1, `BMS_OFF_CTRL, 32'h0000_0004);
    repeat (3) @(posedge pclk);
    chk({factory_restore_mode, restore_kind}, 32'h0000_0006);
    do @(posedge pclk); while (factory_restore_mode !== 1'b0);
    apb(1'b0, `BMS_OFF_STATUS, 32'h0000_0000);
    chk(32'({rd[9], rd[6:4]}), 32'h0000_0008);
  endtask
  ////////////////////////////////////////
  task automatic stop_test;
    $display("checks %0d, mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end
  initial begin
    repeat (20000) @(posedge pclk);
    n_errors++;
    stop_test();
  end
  initial begin
    {presetn, psel, penable, pwrite, drive, pin_hi, brk} = 7'h00;
    {paddr, pwdata, strap} = 47'h0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_modes();
    t_break_hold();
    t_restore(`BMS_RS_PARAMS, 1'b0);
    t_restore(`BMS_RS_IMAGE, 1'b1);
    t_sw_restore();
    stop_test();
  end
endmodule // tb
bind bms_boot bms_props bms_props_inst (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pready(pready), .pslverr(pslverr),
  .wifi_reset_n(wifi_reset_n), .ant_sw_oe(ant_sw_oe),
  .sense_pd_en(sense_pd_en), .wifi_core_reset_n(wifi_core_reset_n),
  .uart_load_mode(uart_load_mode),
  .func_four_wire_debug(func_four_wire_debug),
  .func_two_wire_debug(func_two_wire_debug),
  .factory_restore_mode(factory_restore_mode),
  .restore_kind(restore_kind), .flash_access_deny(flash_access_deny));
`default_nettype wire
